/* src/multi_port_switch.v */
// Four-master, four-slave crossbar switch with per-slave arbitration
// Notes on behaviour
// R1: Four master and four slave ports, independent paths for concurrent pairs.
// R2: 32-bit address and data routed unchanged from granted master to slave.
// R3: Up to four concurrent transactions, any master to any slave.
// R4: Contending masters on one slave: higher priority master is granted.
// R5: Losers wait without error until the owner finishes its transactions.
// R6: Equal priority: round-robin from the id after the last granted master.
// R7: Masters are instruction fetch, load/store data, transfer engine, display controller.
// R8: Slaves: flash, SRAM, serial flash; fourth shared port decodes three regions.
// R9: Configurable per-master priority with reset default; idle masters do not compete.
`include "multi_port_switch_regs.vh"

module multi_port_switch #(
  parameter N = `NUM_PORTS,
  parameter AW = `ADDR_W,
  parameter DW = `DATA_W
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Priority configuration
  input wire prio_wr,
  input wire [N*`PRIO_W-1:0] prio_wdata,
  output reg [N*`PRIO_W-1:0] master_prio,
  // Master side, index is master id
  input wire [N-1:0] m_req,
  input wire [N-1:0] m_lock,
  input wire [N-1:0] m_write,
  input wire [N*AW-1:0] m_addr,
  input wire [N*DW-1:0] m_wdata,
  output reg [N-1:0] m_ack,
  output reg [N*DW-1:0] m_rdata,
  output reg [N-1:0] m_wait,
  // Slave side, index is slave port
  output wire [N-1:0] s_req,
  output wire [N-1:0] s_write,
  output wire [N*AW-1:0] s_addr,
  output wire [N*DW-1:0] s_wdata,
  output wire [N*`ID_W-1:0] s_master,
  output reg [1:0] s3_region,
  input wire [N-1:0] s_ack,
  input wire [N*DW-1:0] s_rdata
);

  wire [N-1:0] done_ack;
  wire [N-1:0] active;
  wire [N*`ID_W-1:0] owner_flat;
  wire [N-1:0] start_vec;
  wire [N*`ID_W-1:0] pick_flat;
  wire [`ID_W-1:0] shared_pick;
  wire shared_start;

  // ==================================================================
  // Priority configuration register
  always @(posedge sys_clk)
  begin
    if (rst)
      master_prio <= `PRIO_RESET; // [R9]
    else if (prio_wr)
      master_prio <= prio_wdata; // [R9]
  end

  // ==================================================================
  // One independent path per slave port
  genvar s;
  genvar m;
  generate
    for (s = 0; s < N; s = s + 1)
    begin : slv
      wire [N-1:0] hit;
      wire gv;
      wire [`ID_W-1:0] gid;
      wire [`ID_W-1:0] pick;
      wire start;
      reg [1:0] st_reg;
      reg [`ID_W-1:0] own_reg;
      reg hold_reg;
      reg lock_reg;
      reg req_reg;
      reg wr_reg;
      reg [AW-1:0] addr_reg;
      reg [DW-1:0] wdata_reg;

      // Only masters requesting this slave compete
      for (m = 0; m < N; m = m + 1)
      begin : dec
        assign hit[m] = m_req[m] && (m_addr[m*AW+`SEL_HI -: 2] == s); // [R8] [R9]
      end

      slave_arbiter #(
        .N(N),
        .IDW(`ID_W),
        .PW(`PRIO_W)
      ) u_arb (
        .sys_clk(sys_clk),
        .rst(rst),
        .req(hit),
        .prio(master_prio),
        .arb_en(st_reg == `ST_IDLE && !hold_reg),
        .grant_valid(gv),
        .grant_id(gid)
      );

      // Owner keeps the port while it holds lock
      assign pick = hold_reg ? own_reg : gid; // [R5]
      assign start = (st_reg == `ST_IDLE) && (hold_reg ? hit[own_reg] : gv); // [R4] [R5]

      always @(posedge sys_clk)
      begin
        if (rst)
        begin
          st_reg <= `ST_IDLE;
          own_reg <= {`ID_W{1'b0}};
          hold_reg <= 1'b0;
          lock_reg <= 1'b0;
          req_reg <= 1'b0;
          wr_reg <= 1'b0;
          addr_reg <= {AW{1'b0}};
          wdata_reg <= {DW{1'b0}};
        end
        else
        begin
          case (st_reg)
            `ST_IDLE:
            begin
              if (start)
              begin
                st_reg <= `ST_BUSY;
                own_reg <= pick;
                lock_reg <= m_lock[pick];
                req_reg <= 1'b1;
                wr_reg <= m_write[pick];
                addr_reg <= m_addr[pick*AW +: AW]; // [R2]
                wdata_reg <= m_wdata[pick*DW +: DW]; // [R2]
              end
            end
            `ST_BUSY:
            begin
              if (s_ack[s])
              begin
                st_reg <= `ST_DONE;
                req_reg <= 1'b0;
                hold_reg <= lock_reg; // [R5]
              end
            end
            `ST_DONE:
              st_reg <= `ST_IDLE;
            default:
              st_reg <= `ST_IDLE;
          endcase
        end
      end

      assign done_ack[s] = (st_reg == `ST_BUSY) && s_ack[s];
      assign active[s] = (st_reg != `ST_IDLE);
      assign owner_flat[s*`ID_W +: `ID_W] = own_reg;
      assign start_vec[s] = start;
      assign pick_flat[s*`ID_W +: `ID_W] = pick;
      assign s_req[s] = req_reg; // [R1] [R3]
      assign s_write[s] = wr_reg;
      assign s_addr[s*AW +: AW] = addr_reg;
      assign s_wdata[s*DW +: DW] = wdata_reg;
      assign s_master[s*`ID_W +: `ID_W] = own_reg; // [R7]
    end
  endgenerate

  // ==================================================================
  // Shared port region decode
  assign shared_pick = slv[N-1].pick;
  assign shared_start = slv[N-1].start;

  always @(posedge sys_clk)
  begin
    if (rst)
      s3_region <= `REGION_DISP_FLASH;
    else if (shared_start)
      s3_region <= m_addr[shared_pick*AW+`REGION_HI -: 2]; // [R8]
  end

  // ==================================================================
  // Return path and wait status per master
  integer i;
  integer j;
  reg [N-1:0] ack_next;
  reg [N-1:0] serving;
  reg [N*DW-1:0] rdata_next;

  always @*
  begin
    ack_next = {N{1'b0}};
    serving = {N{1'b0}};
    rdata_next = m_rdata;
    for (i = 0; i < N; i = i + 1)
    begin
      for (j = 0; j < N; j = j + 1)
      begin
        if (active[j] && owner_flat[j*`ID_W +: `ID_W] == i)
          serving[i] = 1'b1;
        // Master taken at this edge is not stalled
        if (start_vec[j] && pick_flat[j*`ID_W +: `ID_W] == i)
          serving[i] = 1'b1; // [R5]
        if (done_ack[j] && owner_flat[j*`ID_W +: `ID_W] == i)
        begin
          ack_next[i] = 1'b1;
          rdata_next[i*DW +: DW] = s_rdata[j*DW +: DW]; // [R2]
        end
      end
    end
  end

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      m_ack <= {N{1'b0}};
      m_rdata <= {N*DW{1'b0}};
      m_wait <= {N{1'b0}};
    end
    else
    begin
      m_ack <= ack_next;
      m_rdata <= rdata_next;
      m_wait <= m_req & ~serving; // [R5]
    end
  end

endmodule

/* pkg/multi_port_switch_regs.vh */
// Constants for the four-port crossbar switch and its per-slave arbiters
`ifndef MULTI_PORT_SWITCH_REGS_VH
`define MULTI_PORT_SWITCH_REGS_VH

// ==================================================================
// Port counts and path widths
`define NUM_PORTS 4
`define ID_W 2
`define ADDR_W 32
`define DATA_W 32

// ==================================================================
// Master identifiers
`define ID_INSTR 2'h0
`define ID_DATA 2'h1
`define ID_XFER 2'h2
`define ID_DISP 2'h3

// ==================================================================
// Slave select and shared-port region fields of the address
`define SEL_HI 29
`define REGION_HI 27
`define SLAVE_FLASH 2'h0
`define SLAVE_SRAM 2'h1
`define SLAVE_SERIAL 2'h2
`define SLAVE_SHARED 2'h3
`define REGION_DISP_FLASH 2'h0
`define REGION_GFX_SRAM 2'h1
`define REGION_BRIDGE 2'h2

// ==================================================================
// Priority configuration, 0 is the highest level
`define PRIO_W 2
`define PRIO_RESET 8'hE4

// ==================================================================
// Slave path states
`define ST_IDLE 2'h0
`define ST_BUSY 2'h1
`define ST_DONE 2'h2

`endif

/* src/slave_arbiter.v */
// Priority and round-robin arbiter for one slave port
`include "multi_port_switch_regs.vh"

module slave_arbiter #(
  parameter N = 4,
  parameter IDW = 2,
  parameter PW = 2
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Requests and configuration
  input wire [N-1:0] req,
  input wire [N*PW-1:0] prio,
  input wire arb_en,
  // Decision
  output reg grant_valid,
  output reg [IDW-1:0] grant_id
);

  reg [IDW-1:0] last_reg;
  reg [PW-1:0] best;
  reg found;
  integer i;
  integer n;
  integer k;

  // ==================================================================
  // Best priority level among requesters
  always @*
  begin
    best = {PW{1'b1}};
    found = 1'b0;
    for (i = 0; i < N; i = i + 1)
    begin
      if (req[i] && prio[i*PW +: PW] <= best) // [R4] [R9]
      begin
        best = prio[i*PW +: PW];
        found = 1'b1;
      end
    end
  end

  // ==================================================================
  // First requester at that level after the last granted id
  always @*
  begin
    grant_valid = 1'b0;
    grant_id = {IDW{1'b0}};
    for (n = N; n >= 1; n = n - 1)
    begin
      k = (last_reg + n) % N;
      if (found && req[k] && prio[k*PW +: PW] == best) // [R6]
      begin
        grant_valid = 1'b1;
        grant_id = k[IDW-1:0];
      end
    end
  end

  always @(posedge sys_clk)
  begin
    if (rst)
      last_reg <= {IDW{1'b1}};
    else if (arb_en && grant_valid)
      last_reg <= grant_id; // [R6]
  end

endmodule

/* test/multi_port_switch_assertions.sv */
// Port checker for the crossbar switch
module multi_port_switch_assertions (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Priority configuration
  input wire prio_wr,
  input wire [7:0] prio_wdata,
  input wire [7:0] master_prio,
  // Master side
  input wire [3:0] m_req,
  input wire [3:0] m_ack,
  input wire [3:0] m_wait,
  input wire [127:0] m_addr,
  input wire [127:0] m_rdata,
  // Slave side
  input wire [3:0] s_req,
  input wire [3:0] s_ack,
  input wire [127:0] s_addr,
  input wire [127:0] s_rdata,
  input wire [7:0] s_master,
  input wire [1:0] s3_region
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // Checks
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_fin;
    s_req[0] && s_ack[0];
  endsequence
  sequence s_back;
    !s_req[0] && m_ack[s_master[1:0]];
  endsequence
  AST_ACK: assert property (s_fin |=> s_back)
    else $error("ack late");
  AST_ADDR: assert property ($rose(s_req[0]) |-> s_addr[31:0] == m_addr[32*s_master[1:0] +: 32])
    else $error("addr");
  AST_RDATA: assert property (s_req[1] && s_ack[1] |=> m_rdata[32*s_master[3:2] +: 32] == $past(s_rdata[63:32]))
    else $error("rdata");
  AST_HOLD: assert property (s_req[2] && !s_ack[2] |=> s_req[2] && $stable(s_addr[95:64]))
    else $error("hold");
  AST_WAIT: assert property ((m_wait & ~m_req) == 4'h0)
    else $error("wait");
  AST_SERVE: assert property ($rose(s_req[1]) |-> !m_wait[s_master[3:2]])
    else $error("serve");
  AST_PRIO: assert property (prio_wr |=> master_prio == $past(prio_wdata))
    else $error("prio");
  AST_REGION: assert property ($rose(s_req[3]) |-> s3_region == s_addr[123:122])
    else $error("region");
  AST_SEL: assert property ($rose(s_req[2]) |-> s_addr[93:92] == 2'h2)
    else $error("select");
  AST_PULSE: assert property (m_ack[3] |=> !m_ack[3])
    else $error("pulse");
endmodule
bind multi_port_switch multi_port_switch_assertions u_chk (.sys_clk, .rst, .prio_wr, .prio_wdata,
  .master_prio, .s_master, .m_req, .m_ack, .m_wait, .s_req, .s_ack, .m_addr, .m_rdata, .s_addr,
  .s_rdata, .s3_region);

/* test/slave_model.sv */
// Four memory slaves, prompt or slow
module slave_model (
  input wire sys_clk,
  input wire rst,
  input wire [3:0] slow,
  input wire [3:0] s_req,
  input wire [127:0] s_addr,
  output wire [3:0] s_ack,
  output wire [127:0] s_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // Independent slaves
  for (genvar j = 0; j < 4; j++)
  begin : g_slv
    int cnt;
    logic ack_reg;
    logic [31:0] rdata_reg;
    always @(posedge sys_clk)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= ~rdata_reg;
      if (rst)
      begin
        cnt <= 0;
        rdata_reg <= 32'h0F0F0F0F;
      end
      else if (s_req[j] && !ack_reg)
      begin
        cnt <= cnt + 1;
        if (cnt >= (slow[j] ? 3 : 0))
        begin
          // Each slave answers on its own
          ack_reg <= 1'b1;
          rdata_reg <= s_addr[32*j +: 32] ^ 32'hC3C30000;
          cnt <= 0;
        end
      end
    end
    assign s_ack[j] = ack_reg;
    assign s_rdata[32*j +: 32] = rdata_reg;
  end
endmodule

/* test/test_multi_port_switch.sv */
// Testbench for the crossbar switch
module test_multi_port_switch;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 0, rst = 1, prio_wr = 0;
  logic [7:0] prio_wdata = 0, master_prio, s_master;
  logic [3:0] m_req = 0, m_lock = 0, m_write = 0, m_ack, m_wait, s_req, s_write, s_ack, slow = 4'h4;
  logic [127:0] m_addr = 0, m_wdata = 0, m_rdata, s_addr, s_wdata, s_rdata;
  logic [1:0] s3_region;
  int errors = 0, compares = 0;
  int order[$];
  multi_port_switch DUT (.sys_clk, .rst, .prio_wr, .prio_wdata, .master_prio, .m_req, .m_lock,
    .m_write, .m_addr, .m_wdata, .m_ack, .m_rdata, .m_wait, .s_req, .s_write, .s_addr, .s_wdata,
    .s_master, .s3_region, .s_ack, .s_rdata);
  slave_model u_slv (.sys_clk, .rst, .slow, .s_req, .s_addr, .s_ack, .s_rdata);
  initial forever #12.5 sys_clk = ~sys_clk;
  // ==========
  // Shared tasks
  task wrap_up;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic xfer(input int i, input logic [31:0] a, input logic w, input logic l);
    int n;
    @(posedge sys_clk);
    m_req[i] <= 1'b1;
    m_lock[i] <= l;
    m_write[i] <= w;
    m_addr[32*i +: 32] <= a;
    m_wdata[32*i +: 32] <= ~a;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end while (m_ack[i] !== 1'b1 && n < 200);
    if (m_ack[i] !== 1'b1)
    begin
      errors++;
      wrap_up();
    end
    m_req[i] <= 1'b0;
    m_lock[i] <= 1'b0;
    if (!w)
      chk(m_rdata[32*i +: 32], a ^ 32'hC3C30000);
    order.push_back(i);
  endtask
  // ==========
  // Scenarios
  task t_reset;
    chk(master_prio, 8'hE4);
    chk({m_ack, s_req}, 8'h00);
  endtask
  task t_parallel;
    fork
      xfer(0, 32'h00000010, 0, 0);
      xfer(1, 32'h10000020, 1, 0);
      xfer(2, 32'h20000030, 0, 0);
      xfer(3, 32'h34000040, 0, 0);
      begin
        repeat (3) @(posedge sys_clk);
        chk(s_req, 4'hF);
        chk(s3_region, 2'h1);
        chk(s_master, 8'hE4);
        chk(s_write, 4'h2);
        chk(s_wdata[63:32], 32'hEFFFFFDF);
        chk(s_addr[127:96], 32'h34000040);
        chk(m_wait, 4'h0);
      end
    join
  endtask
  task t_contend;
    order.delete();
    fork
      xfer(1, 32'h10000100, 0, 0);
      xfer(2, 32'h10000200, 0, 0);
      begin
        repeat (4) @(posedge sys_clk);
        chk(m_wait, 4'h4);
      end
    join
    chk(order[0], 1);
    chk(order[1], 2);
  endtask
  task set_prio(input logic [7:0] v);
    @(posedge sys_clk);
    prio_wr <= 1'b1;
    prio_wdata <= v;
    @(posedge sys_clk);
    prio_wr <= 1'b0;
    @(posedge sys_clk);
    chk(master_prio, v);
  endtask
  task t_round;
    set_prio(8'h00);
    order.delete();
    fork
      xfer(0, 32'h10000300, 0, 0);
      xfer(2, 32'h10000400, 0, 0);
      xfer(3, 32'h10000500, 0, 0);
    join
    chk(order[0], 3);
    chk(order[1], 0);
    chk(order[2], 2);
  endtask
  // Locked owner keeps flash port against a higher priority master
  task t_lock;
    set_prio(8'h3F);
    order.delete();
    fork
      begin
        xfer(0, 32'h00000500, 0, 1);
        xfer(0, 32'h00000600, 0, 0);
      end
      begin
        repeat (2) @(posedge sys_clk);
        xfer(3, 32'h00000700, 0, 0);
      end
      begin
        repeat (7) @(posedge sys_clk);
        chk(m_wait, 4'h8);
        chk(s_req, 4'h0);
      end
    join
    chk(order[0], 0);
    chk(order[1], 0);
    chk(order[2], 3);
  endtask
  initial
  begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_parallel();
    t_contend();
    t_round();
    t_lock();
    wrap_up();
  end
endmodule
